// File: verilog/fsb_pkg.sv
// package for the fault status, sticky flag and mask bank
// assumes a management-port front end that turns serial frames into byte strobes
package fsb_pkg;
    // -----------------------------------------------------------------
    // register offsets within page 0
    // -----------------------------------------------------------------
    localparam logic [7:0] FSB_PAGE_OFS     = 8'h01;
    localparam logic [7:0] FSB_TEMP_OFS     = 8'h09;
    localparam logic [7:0] FSB_PKG_OFS      = 8'h0A;
    localparam logic [7:0] FSB_ADDR_OFS     = 8'h0B;
    localparam logic [7:0] FSB_DEV_ST_OFS   = 8'h0C;
    localparam logic [7:0] FSB_IN_ST_OFS    = 8'h0D;
    localparam logic [7:0] FSB_PLL_ST_OFS   = 8'h0E;
    localparam logic [7:0] FSB_CAL_ST_OFS   = 8'h0F;
    localparam logic [7:0] FSB_DEV_FLG_OFS  = 8'h11;
    localparam logic [7:0] FSB_IN_FLG_OFS   = 8'h12;
    localparam logic [7:0] FSB_PLL_FLG_OFS  = 8'h13;
    localparam logic [7:0] FSB_CAL_FLG_OFS  = 8'h14;
    localparam logic [7:0] FSB_DEV_MSK_OFS  = 8'h17;
    // -----------------------------------------------------------------
    // defined-bit masks and reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] FSB_DEV_BITS     = 8'h2F;   // bits 0..3 and 5
    localparam logic [7:0] FSB_CAL_BITS     = 8'hF0;   // bits 7:4
    localparam logic [7:0] FSB_ALL_BITS     = 8'hFF;
    localparam logic [7:0] FSB_ADDR_BITS    = 8'h7F;   // seven-bit address
    localparam logic [7:0] FSB_PAGE_RST     = 8'h00;
    localparam logic [7:0] FSB_MSK_RST      = 8'h00;
    localparam logic [7:0] FSB_FLG_RST      = 8'h00;
    localparam logic [7:0] FSB_ZERO         = 8'h00;
    // address field split
    localparam int         FSB_PIN_BITS     = 2;
    // -----------------------------------------------------------------
    // register port carrier
    // -----------------------------------------------------------------
    typedef struct packed {
        logic       wr;      // one-cycle write strobe
        logic       rd;      // one-cycle read strobe
        logic [7:0] addr;    // offset within page
        logic [7:0] wdata;   // write byte
    } fsb_req_s;
    // live fault inputs from the detectors
    typedef struct packed {
        logic       device_calibrating;
        logic       crystal_ref_signal_lost;
        logic       ref_signal_undetected;
        logic       crystal_ref_lock_error;
        logic       mgmt_bus_timeout;
        logic [3:0] input_signal_lost;
        logic [3:0] input_freq_out_of_range;
        logic [3:0] pll_unlocked;
        logic [3:0] pll_holdover;
        logic [3:0] pll_cal_busy;
    } fsb_fault_s;
endpackage

// File: verilog/fsb_bank.sv
// fault status, sticky flag and interrupt mask bank, page 0 registers
// assumes the serial front end presents decoded byte strobes on mclk_i;
// fault inputs and address pins are asynchronous and are synchronised here
`timescale 1ns/10ps
module fsb_bank #(
    parameter logic [7:0] TEMP_GRADE_VAL = 8'h00,   // arbitrary identification value
    parameter logic [7:0] PACKAGE_ID_VAL = 8'h00,   // arbitrary identification value
    parameter logic [4:0] ADDR_UPPER_VAL = 5'h1A    // upper address bits, arbitrary
) (
    input  wire logic               mclk_i,
    input  wire logic               rst_b_i,
    input  wire logic               clk_en_i,
    input  wire fsb_pkg::fsb_req_s  req_i,
    output logic [7:0]              rdata_o,
    output logic                    rvalid_o,
    output logic [7:0]              page_o,
    input  wire fsb_pkg::fsb_fault_s fault_i,
    input  wire logic               address_select_high_pin_i,
    input  wire logic               address_select_low_pin_i,
    output logic [6:0]              nvm_save_addr_o,
    output logic                    interrupt_out_n_o
);
    import fsb_pkg::*;

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    localparam int NSYNC = 2 + 5 + 20;  // two pins, five device levels, five nibbles
    logic [NSYNC-1:0] sync_a;      // first stage, read only by sync_b
    logic [NSYNC-1:0] sync_b;      // second stage, safe to use
    logic [NSYNC-1:0] raw_in;      // packed asynchronous inputs

    assign raw_in = {address_select_high_pin_i, address_select_low_pin_i,
                     fault_i.device_calibrating, fault_i.crystal_ref_signal_lost,
                     fault_i.ref_signal_undetected, fault_i.crystal_ref_lock_error,
                     fault_i.mgmt_bus_timeout, fault_i.input_signal_lost,
                     fault_i.input_freq_out_of_range, fault_i.pll_unlocked,
                     fault_i.pll_holdover, fault_i.pll_cal_busy};

    // two flops for every outside level
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (clk_en_i) begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    // -----------------------------------------------------------------
    // live status assembly
    // -----------------------------------------------------------------
    logic [7:0] live [4];          // index 0 device, 1 input, 2 pll, 3 cal
    logic [1:0] addr_pins;         // synchronised address pin levels

    assign addr_pins = sync_b[26:25];
    // device status: calibrating bit0, crystal lost bit1, ref undetected bit2,
    // crystal lock error bit3, bus timeout bit5; bits 4,6,7 read zero
    assign live[0] = {2'b00, sync_b[20], 1'b0, sync_b[21], sync_b[22],
                      sync_b[23], sync_b[24]};
    // inputs: frequency in 7:4, lost in 3:0
    assign live[1] = {sync_b[15:12], sync_b[19:16]};
    // plls: holdover in 7:4, unlocked in 3:0
    assign live[2] = {sync_b[7:4], sync_b[11:8]};
    // calibration busy in 7:4 only, pll a in bit 4
    assign live[3] = {sync_b[3:0], 4'h0};

    // -----------------------------------------------------------------
    // decode helpers
    // -----------------------------------------------------------------
    // defined bits of each flag group
    function automatic logic [7:0] grp_bits(input int g);
        case (g)
            0:       grp_bits = FSB_DEV_BITS;
            3:       grp_bits = FSB_CAL_BITS;
            default: grp_bits = FSB_ALL_BITS;
        endcase
    endfunction

    // flag offset of each group
    function automatic logic [7:0] flg_ofs(input int g);
        case (g)
            0:       flg_ofs = FSB_DEV_FLG_OFS;
            1:       flg_ofs = FSB_IN_FLG_OFS;
            2:       flg_ofs = FSB_PLL_FLG_OFS;
            default: flg_ofs = FSB_CAL_FLG_OFS;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // sticky flags
    // -----------------------------------------------------------------
    logic [7:0] cal_live;          // calibration status, busy in 7:4
    logic [7:0] flags [4];         // sticky flag registers

    assign cal_live = live[3];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_flag
            logic [7:0] src;       // live bits feeding this group
            logic [7:0] clr;       // bits the host wrote to zero
            assign src = live[g];
            assign clr = (req_i.wr && page_o == FSB_PAGE_RST && req_i.addr == flg_ofs(g))
                         ? (~req_i.wdata & grp_bits(g)) : FSB_ZERO;
            // set wins over clear; a clear is ignored while live bit stays high
            always_ff @(posedge mclk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    flags[g] <= FSB_FLG_RST;
                end else if (clk_en_i) begin
                    flags[g] <= ((flags[g] & ~(clr & ~src)) | src) & grp_bits(g);
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // page and mask registers
    // -----------------------------------------------------------------
    logic [7:0] dev_mask;          // device flag interrupt masks
    logic       pg0;               // page 0 is selected

    assign pg0 = (page_o == FSB_PAGE_RST);

    // page select is present on every page
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            page_o <= FSB_PAGE_RST;
        end else if (clk_en_i && req_i.wr && req_i.addr == FSB_PAGE_OFS) begin
            page_o <= req_i.wdata;
        end
    end

    // masks, defined bits only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dev_mask <= FSB_MSK_RST;
        end else if (clk_en_i && req_i.wr && pg0 && req_i.addr == FSB_DEV_MSK_OFS) begin
            dev_mask <= req_i.wdata & FSB_DEV_BITS;
        end
    end

    // -----------------------------------------------------------------
    // serial bus address
    // -----------------------------------------------------------------
    logic [6:0] bus_addr;          // read-only seven-bit address

    // upper bits from the stored value, lower two follow the pins
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_addr <= 7'h00;
        end else if (clk_en_i) begin
            bus_addr <= {ADDR_UPPER_VAL, addr_pins};
        end
    end
    // the save path only sees the stored upper bits, never the pin levels
    assign nvm_save_addr_o = {ADDR_UPPER_VAL, 2'b00};

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    logic [7:0] next_rdata;        // byte selected by the read offset

    always_comb begin
        next_rdata = FSB_ZERO;
        if (req_i.addr == FSB_PAGE_OFS) begin
            next_rdata = page_o;
        end else if (pg0) begin
            case (req_i.addr)
                FSB_TEMP_OFS:    next_rdata = TEMP_GRADE_VAL;
                FSB_PKG_OFS:     next_rdata = PACKAGE_ID_VAL;
                FSB_ADDR_OFS:    next_rdata = {1'b0, bus_addr};
                FSB_DEV_ST_OFS:  next_rdata = live[0];
                FSB_IN_ST_OFS:   next_rdata = live[1];
                FSB_PLL_ST_OFS:  next_rdata = live[2];
                FSB_CAL_ST_OFS:  next_rdata = cal_live & FSB_CAL_BITS;
                FSB_DEV_FLG_OFS: next_rdata = flags[0];
                FSB_IN_FLG_OFS:  next_rdata = flags[1];
                FSB_PLL_FLG_OFS: next_rdata = flags[2];
                FSB_CAL_FLG_OFS: next_rdata = flags[3];
                FSB_DEV_MSK_OFS: next_rdata = dev_mask;
                default:         next_rdata = FSB_ZERO;
            endcase
        end
    end

    // read data registered, valid one cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o  <= FSB_ZERO;
            rvalid_o <= 1'b0;
        end else if (clk_en_i) begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= next_rdata;
            end
        end
    end

    // -----------------------------------------------------------------
    // interrupt output
    // -----------------------------------------------------------------
    // the device flags are gated by their masks; other groups have masks
    // elsewhere and do not drive this output
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            interrupt_out_n_o <= 1'b1;
        end else if (clk_en_i) begin
            interrupt_out_n_o <= ~|(flags[0] & ~dev_mask);
        end
    end

endmodule // fsb_bank

// File: tb/fsb_bank_monitor.sv
// checker for the fault flag bank: read strobes, page, live status and interrupt
// assumes it is bound to fsb_bank and sees only that module's ports
`timescale 1ns/10ps
module fsb_bank_monitor #(
    parameter logic [4:0] ADDR_UPPER_VAL = 5'h1A   // must match the bank
) (
    input wire logic               mclk_i,
    input wire logic               rst_b_i,
    input wire logic               clk_en_i,
    input wire fsb_pkg::fsb_req_s  req_i,
    input wire logic [7:0]         rdata_o,
    input wire logic               rvalid_o,
    input wire logic [7:0]         page_o,
    input wire fsb_pkg::fsb_fault_s fault_i,
    input wire logic               address_select_high_pin_i,
    input wire logic               address_select_low_pin_i,
    input wire logic [6:0]         nvm_save_addr_o,
    input wire logic               interrupt_out_n_o
);
    import fsb_pkg::*;
    // ---------------------------------------------------------------
    // helper terms: taken reads and the expected status bytes
    // ---------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic       rd_any;   // read taken on any page
    logic       rd0;      // read taken on page 0
    logic [7:0] dev_exp;  // device status byte
    logic [7:0] in_exp;   // input status byte
    logic [7:0] cal_exp;  // calibration status byte
    assign rd_any = clk_en_i && req_i.rd;
    assign rd0 = rd_any && page_o == 8'h00;
    assign dev_exp = {2'b00, fault_i.mgmt_bus_timeout, 1'b0, fault_i.crystal_ref_lock_error,
                      fault_i.ref_signal_undetected, fault_i.crystal_ref_signal_lost, fault_i.device_calibrating};
    assign in_exp = {fault_i.input_freq_out_of_range, fault_i.input_signal_lost};
    assign cal_exp = {fault_i.pll_cal_busy, 4'h0};
    a_rvalid_follows_read: assert property (rd_any |=> rvalid_o) else $error("no read answer");
    a_rvalid_single_pulse: assert property (!rd_any |=> !rvalid_o) else $error("stray read answer");
    a_page_write_takes: assert property (clk_en_i && req_i.wr && req_i.addr == FSB_PAGE_OFS
        |=> page_o == $past(req_i.wdata)) else $error("page not written");
    a_rdata_holds_still: assert property (!rd_any |=> $stable(rdata_o)) else $error("read byte moved");
    a_save_addr_fixed: assert property (nvm_save_addr_o[6:2] == ADDR_UPPER_VAL && $stable(nvm_save_addr_o))
        else $error("save address moved");
    a_mask_quiets_irq: assert property (clk_en_i && req_i.wr && page_o == 8'h00 && req_i.addr == FSB_DEV_MSK_OFS
        && (req_i.wdata & FSB_DEV_BITS) == FSB_DEV_BITS |=> ##[0:2] interrupt_out_n_o)
        else $error("masked flags still interrupt");
    a_dev_status_live: assert property ($stable(fault_i) [*5] ##0 (rd0 && req_i.addr == FSB_DEV_ST_OFS)
        |=> rdata_o == $past(dev_exp)) else $error("device status wrong");
    a_input_status_live: assert property ($stable(fault_i) [*5] ##0 (rd0 && req_i.addr == FSB_IN_ST_OFS)
        |=> rdata_o == $past(in_exp)) else $error("input status wrong");
    a_cal_status_live: assert property ($stable(fault_i) [*5] ##0 (rd0 && req_i.addr == FSB_CAL_ST_OFS)
        |=> rdata_o == $past(cal_exp)) else $error("calibration status wrong");
endmodule // fsb_bank_monitor
bind fsb_bank fsb_bank_monitor #(.ADDR_UPPER_VAL(ADDR_UPPER_VAL)) u_fsb_bank_monitor (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .page_o(page_o), .fault_i(fault_i), .address_select_high_pin_i(address_select_high_pin_i),
    .address_select_low_pin_i(address_select_low_pin_i), .nvm_save_addr_o(nvm_save_addr_o),
    .interrupt_out_n_o(interrupt_out_n_o));

// File: tb/fsb_host_model.sv
// host side model: single-byte register reads and writes on the bank strobes
// assumes requests change 1 ns after the rising edge of mclk_i
`timescale 1ns/10ps
module fsb_host_model (
    input  wire logic         mclk_i,
    input  wire logic         rvalid_i,
    input  wire logic [7:0]   rdata_i,
    output fsb_pkg::fsb_req_s req_o
);
    import fsb_pkg::*;
    initial req_o = '0;
    // one write strobe for exactly one taken edge, then the address is scrambled
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge mclk_i) #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dt};
        @(posedge mclk_i) #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dt};
    endtask
    // one read strobe; the answer is taken in the cycle after the taken edge
    task automatic rd(input logic [7:0] a, output logic [7:0] dt, output logic ok);
        @(posedge mclk_i) #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk_i) #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        ok = rvalid_i;
        dt = rdata_i;
    endtask
endmodule // fsb_host_model

// File: tb/testbench.sv
// self-checking bench: host reads and writes against detector levels
// assumes fsb_pkg, the bank, its monitor and the host model compile first
`timescale 1ns/10ps
module testbench;
    import fsb_pkg::*;
    logic       mclk_i = 1'b0;           // 100 MHz clock
    logic       rst_b_i = 1'b0;          // reset, active low
    fsb_req_s   req;                     // strobes from the host model
    fsb_fault_s fault = '0;              // detector levels
    fsb_fault_s pat [2];                 // two complementary fault patterns
    logic       pin_hi = 1'b1;           // address select high pin
    logic       pin_lo = 1'b0;           // address select low pin
    logic [7:0] rdata, page, d;
    logic       rvalid, irq_n, ok;
    logic [6:0] save_addr, save0;
    logic [7:0] st [2][4];               // expected status per pattern
    logic [7:0] fo [4] = '{8'h11, 8'h12, 8'h13, 8'h14};
    logic [7:0] zr [11] = '{8'h01, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h17};
    int         error_cnt = 0;
    int         compares = 0;
    always #5 mclk_i = ~mclk_i;
    fsb_bank u_fsb_bank (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .req_i(req), .rdata_o(rdata),
        .rvalid_o(rvalid), .page_o(page), .fault_i(fault), .address_select_high_pin_i(pin_hi),
        .address_select_low_pin_i(pin_lo), .nvm_save_addr_o(save_addr), .interrupt_out_n_o(irq_n));
    fsb_host_model u_fsb_host_model (.mclk_i(mclk_i), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));
    // compare one byte and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // read a register and check both the answer strobe and the byte
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_fsb_host_model.rd(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    // main sequence
    initial begin
        pat[0] = {5'b10010, 20'h5A3C9};
        pat[1] = {5'b01101, 20'hA5C36};
        st[0] = '{8'h09, 8'hA5, 8'hC3, 8'h90};
        st[1] = '{8'h26, 8'h5A, 8'h3C, 8'h60};
        wt(6);
        rst_b_i = 1'b1;
        u_fsb_host_model.wr(8'h10, 8'hFF);
        wt(4);
        foreach (zr[i]) rchk(zr[i], 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        save0 = save_addr;
        rchk(FSB_ADDR_OFS, 8'h6A);
        u_fsb_host_model.wr(FSB_ADDR_OFS, 8'h00);
        {pin_hi, pin_lo} = 2'b01;
        wt(5);
        rchk(FSB_ADDR_OFS, 8'h69);
        chk({1'b0, save_addr}, {1'b0, save0});
        for (int p = 0; p < 2; p++) begin
            fault = pat[p];
            wt(5);
            for (int r = 0; r < 4; r++) rchk(FSB_DEV_ST_OFS + 8'(r), st[p][r]);
        end
        foreach (fo[i]) rchk(fo[i], i == 0 ? 8'h2F : (i == 3 ? 8'hF0 : 8'hFF));
        chk({7'h00, irq_n}, 8'h00);
        foreach (fo[i]) u_fsb_host_model.wr(fo[i], 8'h00);
        foreach (fo[i]) rchk(fo[i], st[1][i]);
        fault = '0;
        wt(5);
        u_fsb_host_model.wr(FSB_DEV_FLG_OFS, 8'hFF);
        rchk(FSB_DEV_FLG_OFS, 8'h26);
        foreach (fo[i]) u_fsb_host_model.wr(fo[i], 8'h00);
        foreach (fo[i]) rchk(fo[i], 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        fault.device_calibrating = 1'b1;
        wt(5);
        chk({7'h00, irq_n}, 8'h00);
        u_fsb_host_model.wr(FSB_DEV_MSK_OFS, 8'hFF);
        rchk(FSB_DEV_MSK_OFS, 8'h2F);
        chk({7'h00, irq_n}, 8'h01);
        u_fsb_host_model.wr(FSB_DEV_MSK_OFS, 8'h2E);
        wt(3);
        chk({7'h00, irq_n}, 8'h00);
        u_fsb_host_model.wr(FSB_PAGE_OFS, 8'h05);
        rchk(FSB_PAGE_OFS, 8'h05);
        rchk(FSB_DEV_ST_OFS, 8'h00);
        u_fsb_host_model.wr(FSB_PAGE_OFS, 8'h00);
        rchk(FSB_DEV_ST_OFS, 8'h01);
        end_sim();
    end
endmodule // testbench
